/* File: inc/ocss_pkg.sv */
// Purpose: shared constants for the output clock source select block
// Assumes: byte-wide register port, one register per byte address
// Notes: pick codes are the three-bit source codes of outputs four to seven

package ocss_pkg;

   // ************************************************************
   // register byte addresses
   // ************************************************************
   localparam logic [15:0] OCSS_ADDR_LOW_SRC = 16'h00A8;
   localparam logic [15:0] OCSS_ADDR_PAIR_45 = 16'h00A9;
   localparam logic [15:0] OCSS_ADDR_PAIR_67 = 16'h00AA;
   localparam logic [15:0] OCSS_ADDR_RSVD = 16'h00AB;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int OCSS_FIRST_HOLD_BIT = 4;
   localparam int OCSS_SECOND_HOLD_BIT = 5;
   localparam int OCSS_PAIR_HI_LSB = 4;
   localparam int OCSS_PICK_W = 3;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [5:0] OCSS_LOW_SRC_RESET = 6'h0A;
   localparam logic [11:0] OCSS_HIGH_PICK_RESET = 12'hA10;

   // ************************************************************
   // three-bit source codes
   // ************************************************************
   localparam logic [2:0] OCSS_SRC_FIRST_LOOP = 3'h0;
   localparam logic [2:0] OCSS_SRC_SECOND_LOOP = 3'h1;
   localparam logic [2:0] OCSS_SRC_OUT2 = 3'h2;
   localparam logic [2:0] OCSS_SRC_OUT3 = 3'h3;
   localparam logic [2:0] OCSS_SRC_REF_ZERO = 3'h4;
   localparam logic [2:0] OCSS_SRC_REF_ONE = 3'h5;
   localparam logic [2:0] OCSS_SRC_RESERVED = 3'h6;
   localparam logic [2:0] OCSS_SRC_CRYSTAL = 3'h7;

endpackage

/* File: core/ocss_route_dec.sv */
// Purpose: works out which internal loop ultimately feeds each output
// Assumes: outputs two and three are always fed by one of the two loops
// Notes: references, crystal and the reserved code belong to no loop

`timescale 1ns/10ps

module ocss_route_dec (
   input wire logic [3:0] low_pick_in,
   input wire logic [11:0] high_pick_in,
   output logic [7:0] first_mask_out,
   output logic [7:0] second_mask_out
);

   // ************************************************************
   // decode
   // ************************************************************

   // returns {second loop, first loop} membership of one three-bit pick
   function automatic logic [1:0] loop_of(input logic [2:0] code, input logic [3:0] low);
      logic [1:0] r;
      r = 2'h0;
      case (code)
         ocss_pkg::OCSS_SRC_FIRST_LOOP: r = 2'h1;
         ocss_pkg::OCSS_SRC_SECOND_LOOP: r = 2'h2;
         ocss_pkg::OCSS_SRC_OUT2: r = low[2] ? 2'h2 : 2'h1; // follows output two
         ocss_pkg::OCSS_SRC_OUT3: r = low[3] ? 2'h2 : 2'h1; // follows output three
         default: r = 2'h0; // references, crystal, reserved code
      endcase
      return r;
   endfunction

   // membership masks for all eight outputs
   always_comb begin
      logic [1:0] m;
      m = 2'h0;
      first_mask_out[3:0] = ~low_pick_in; // 0 picks first loop
      second_mask_out[3:0] = low_pick_in; // 1 picks second loop
      for (int j = 0; j < 4; j++) begin
         m = loop_of(high_pick_in[j*3 +: 3], low_pick_in);
         first_mask_out[j+4] = m[0];
         second_mask_out[j+4] = m[1];
      end
   end

endmodule

/* File: core/ocss_top.sv */
// Purpose: output clock source selection and per-loop output divider sync
// Assumes: register port driven by logic on CLK_IN, one access per cycle
// Notes: divider holds and coarse clears follow the live source picks

`timescale 1ns/10ps

module ocss_top (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic [15:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic [3:0] LOW_PICK_OUT,
   output logic [11:0] HIGH_PICK_OUT,
   output logic [7:0] DIV_HOLD_OUT,
   output logic [7:0] COARSE_CLEAR_OUT
);

   // ************************************************************
   // register storage
   // ************************************************************
   logic [5:0] low_src;
   logic [11:0] high_pick;
   logic first_hold;
   logic second_hold;
   logic first_hold_d;
   logic second_hold_d;
   logic [7:0] first_mask;
   logic [7:0] second_mask;
   logic first_fall;
   logic second_fall;
   logic [7:0] next_hold;
   logic [7:0] next_clear;

   assign first_hold = low_src[ocss_pkg::OCSS_FIRST_HOLD_BIT];
   assign second_hold = low_src[ocss_pkg::OCSS_SECOND_HOLD_BIT];

   // register writes; reserved bits are dropped
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         low_src <= ocss_pkg::OCSS_LOW_SRC_RESET;
         high_pick <= ocss_pkg::OCSS_HIGH_PICK_RESET;
      end else if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            ocss_pkg::OCSS_ADDR_LOW_SRC: begin
               low_src <= REG_WDATA_IN[5:0];
            end
            ocss_pkg::OCSS_ADDR_PAIR_45: begin
               high_pick[2:0] <= REG_WDATA_IN[2:0];
               high_pick[5:3] <= REG_WDATA_IN[ocss_pkg::OCSS_PAIR_HI_LSB +: 3];
            end
            ocss_pkg::OCSS_ADDR_PAIR_67: begin
               high_pick[8:6] <= REG_WDATA_IN[2:0];
               high_pick[11:9] <= REG_WDATA_IN[ocss_pkg::OCSS_PAIR_HI_LSB +: 3];
            end
            default: begin
               low_src <= low_src;
            end
         endcase
      end
   end

   // register reads; reserved bits and unmapped addresses read zero
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else if (REG_RD_IN) begin
         case (REG_ADDR_IN)
            ocss_pkg::OCSS_ADDR_LOW_SRC: REG_RDATA_OUT <= {2'h0, low_src};
            ocss_pkg::OCSS_ADDR_PAIR_45: REG_RDATA_OUT <= {1'h0, high_pick[5:3], 1'h0,
                                                          high_pick[2:0]};
            ocss_pkg::OCSS_ADDR_PAIR_67: REG_RDATA_OUT <= {1'h0, high_pick[11:9], 1'h0,
                                                          high_pick[8:6]};
            default: REG_RDATA_OUT <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // source routing
   // ************************************************************

   // loop membership of each output from the live picks
   ocss_route_dec i_ocss_route_dec (
      .low_pick_in(low_src[3:0]),
      .high_pick_in(high_pick),
      .first_mask_out(first_mask),
      .second_mask_out(second_mask)
   );

   // pick outputs to the clock muxes
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         LOW_PICK_OUT <= ocss_pkg::OCSS_LOW_SRC_RESET[3:0];
         HIGH_PICK_OUT <= ocss_pkg::OCSS_HIGH_PICK_RESET;
      end else begin
         LOW_PICK_OUT <= low_src[3:0];
         HIGH_PICK_OUT <= high_pick;
      end
   end

   // ************************************************************
   // divider sync
   // ************************************************************

   // previous sync bits for falling edge detection
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         first_hold_d <= 1'b0;
         second_hold_d <= 1'b0;
      end else begin
         first_hold_d <= first_hold;
         second_hold_d <= second_hold;
      end
   end

   assign first_fall = first_hold_d & ~first_hold;
   assign second_fall = second_hold_d & ~second_hold;

   // hold follows current membership, so all affected dividers drop together
   assign next_hold = ({8{first_hold}} & first_mask)
                    | ({8{second_hold}} & second_mask);

   // one-cycle coarse clear, also the load point for new fine steps
   assign next_clear = ({8{first_fall}} & first_mask)
                     | ({8{second_fall}} & second_mask);

   // divider hold and coarse clear outputs
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         DIV_HOLD_OUT <= 8'h00;
         COARSE_CLEAR_OUT <= 8'h00;
      end else begin
         DIV_HOLD_OUT <= next_hold;
         COARSE_CLEAR_OUT <= next_clear;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************

   a_hold_second_set:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      second_hold |=> ((DIV_HOLD_OUT & $past(second_mask)) == $past(second_mask)))
   else $error("second loop dividers not held");

   a_hold_first_set:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      $rose(first_hold) ##0 first_hold [*2]
      |-> ((DIV_HOLD_OUT & $past(first_mask)) == $past(first_mask)))
   else $error("first loop dividers not held");

   a_release_clears:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      $fell(first_hold)
      |=> ((DIV_HOLD_OUT & $past(first_mask)) == 8'h00)
          && ((COARSE_CLEAR_OUT & $past(first_mask)) == $past(first_mask)))
   else $error("first loop release or coarse clear wrong");

   a_no_clear_held:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (first_hold && second_hold) |=> (COARSE_CLEAR_OUT == 8'h00))
   else $error("coarse clear while both loops held");

   a_low_route:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (first_mask[3:0] == ~LOW_PICK_OUT) || $changed(low_src[3:0]) || $changed(LOW_PICK_OUT))
   else $error("low output routing wrong");

   a_high_route:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (high_pick[2:0] == ocss_pkg::OCSS_SRC_OUT3)
      |-> (first_mask[4] == first_mask[3]) && (second_mask[4] == second_mask[3]))
   else $error("output four does not follow output three");

   a_no_loop_ref:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      high_pick[11] |-> !first_mask[7] && !second_mask[7])
   else $error("output seven on a loop with a non-loop code");

   a_reset_picks:
   assert property (@(posedge CLK_IN)
      $rose(RESETN_IN) |-> (LOW_PICK_OUT == 4'hA) && (HIGH_PICK_OUT == 12'hA10)
                        && (DIV_HOLD_OUT == 8'h00))
   else $error("pick values after reset wrong");

   a_rsvd_read:
   assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (REG_RD_IN && (REG_ADDR_IN == ocss_pkg::OCSS_ADDR_LOW_SRC))
      |=> (REG_RDATA_OUT[7:6] == 2'h0) && (REG_RDATA_OUT[5:0] == $past(low_src)))
   else $error("low source read wrong");

endmodule

/* File: sim/ocss_top_bench.sv */
// Purpose: self-checking bench for the output clock source select block
// Assumes: byte strobe register port, one clock, asynchronous active-low reset
// Notes: expected hold masks are worked out here from the source pick meaning

`timescale 1ns/10ps

module ocss_top_bench;

   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [3:0] low_pick;
   logic [11:0] high_pick;
   logic [7:0] hold;
   logic [7:0] clr;
   int fails = 0;
   int cmp_count = 0;

   // clock of 25 ns period
   always #12.5 clk = ~clk;

   ocss_top i_ocss_top (
      .CLK_IN(clk),
      .RESETN_IN(resetn),
      .REG_ADDR_IN(addr),
      .REG_WR_IN(wr),
      .REG_WDATA_IN(wdata),
      .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata),
      .LOW_PICK_OUT(low_pick),
      .HIGH_PICK_OUT(high_pick),
      .DIV_HOLD_OUT(hold),
      .COARSE_CLEAR_OUT(clr)
   );

   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // outputs fed by the chosen loop, outputs 4-7 may follow output 2 or 3
   function automatic logic [7:0] loop_mask(input logic [3:0] lo, input logic [11:0] hi,
                                            input logic lp);
      logic [7:0] m;
      logic [2:0] c;
      for (int i = 0; i < 4; i++) begin
         m[i] = (lo[i] == lp);
         c = hi[3*i +: 3];
         m[4+i] = (c == {2'b00, lp}) || (c == 3'h2 && lo[2] == lp) || (c == 3'h3 && lo[3] == lp);
      end
      return m;
   endfunction

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #2;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #2;
      wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      #2;
      addr = a;
      rd = 1'b1;
      @(posedge clk);
      #2;
      rd = 1'b0;
      @(posedge clk);
      #1;
      chk({4'h0, rdata}, {4'h0, exp});
   endtask

   // bounded wait for the divider holds to reach the expected set
   task automatic wait_hold(input logic [7:0] exp);
      int i;
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         if (hold === exp) break;
      end
      chk({4'h0, hold}, {4'h0, exp});
      if (i == 4) print_verdict();
   endtask

   // clears the sync bits and expects one clear pulse on the released outputs
   task automatic sync_off(input logic [3:0] lo, input logic [7:0] exp);
      int i;
      reg_wr(16'h00A8, {4'h0, lo});
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         if (clr !== 8'h00) break;
      end
      chk({4'h0, clr}, {4'h0, exp});
      chk({4'h0, hold}, 12'h000);
      if (i == 4) print_verdict();
      @(posedge clk);
      #1;
      chk({4'h0, clr}, 12'h000);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic check_reset();
      chk({8'h0, low_pick}, 12'h00A);
      chk(high_pick, 12'hA10);
      chk({4'h0, hold}, 12'h000);
      reg_rd(16'h00A8, 8'h0A);
      reg_rd(16'h00A9, 8'h20);
      reg_rd(16'h00AA, 8'h50);
   endtask

   task automatic check_sync(input logic [3:0] lo, input logic [11:0] hi);
      reg_wr(16'h00A9, {1'b0, hi[5:3], 1'b0, hi[2:0]});
      reg_wr(16'h00AA, {1'b0, hi[11:9], 1'b0, hi[8:6]});
      reg_wr(16'h00A8, {4'h0, lo});
      @(posedge clk);
      #1;
      chk({8'h0, low_pick}, {8'h0, lo});
      chk(high_pick, hi);
      for (int lp = 0; lp < 2; lp++) begin
         reg_wr(16'h00A8, {2'b00, lp == 1, lp == 0, lo});
         wait_hold(loop_mask(lo, hi, lp[0]));
         sync_off(lo, loop_mask(lo, hi, lp[0]));
      end
   endtask

   task automatic live_move();
      logic [11:0] hi;
      hi = {3'h2, 3'h3, 3'h2, 3'h2};
      reg_wr(16'h00A9, {1'b0, hi[5:3], 1'b0, hi[2:0]});
      reg_wr(16'h00AA, {1'b0, hi[11:9], 1'b0, hi[8:6]});
      reg_wr(16'h00A8, 8'h10);
      wait_hold(loop_mask(4'h0, hi, 1'b0));
      reg_wr(16'h00A8, 8'h14);
      wait_hold(loop_mask(4'h4, hi, 1'b0));
      sync_off(4'h4, loop_mask(4'h4, hi, 1'b0));
   endtask

   // reserved positions are always written as zero by software
   task automatic reserved_bits();
      reg_wr(16'h00A9, 8'h77);
      reg_rd(16'h00A9, 8'h77);
      reg_wr(16'h00AB, 8'h00);
      reg_rd(16'h00AB, 8'h00);
      reg_rd(16'h00B0, 8'h00);
   endtask

   // reset in mid-run while second loop dividers are held
   task automatic mid_reset();
      reg_wr(16'h00A8, 8'h2A);
      wait_hold(loop_mask(4'hA, 12'hA10, 1'b1));
      @(posedge clk);
      #2;
      resetn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({4'h0, hold}, 12'h000);
      chk({4'h0, clr}, 12'h000);
      #1;
      resetn = 1'b1;
      check_reset();
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      #2;
      resetn = 1'b1;
      check_reset();
      mid_reset();
      check_sync(4'b1000, {3'h3, 3'h2, 3'h1, 3'h0});
      // code 110 never written; no reference clock runs, so reference picks stay slow
      check_sync(4'b0110, {3'h7, 3'h7, 3'h5, 3'h4});
      check_sync(4'b0100, {3'h2, 3'h3, 3'h3, 3'h2});
      live_move();
      reserved_bits();
      print_verdict();
   end

endmodule
